// ---- mhwio_core.v ----
/*
 * Host watchdog command handling and point map of a remote I/O module.
 * Assumes a serial layer that delivers checked request bytes with an
 * end-of-frame pulse and accepts reply bytes under valid/ready.
 */
//
// Overview of operation
// - status read, fc01 at 0x010D, one byte
// - status byte 0x00 clear, 0x01 set
// - timeout read, fc03 at 0x01E8, two bytes
// - timeout held 0..255 tenths of second
// - host-alive fc03/04 at 0x3038, no reply
// - coil 0x0104 FF00 enables, 0000 disables
// - coil 0x010D FF00 clears expired flag
// - fc06 to 0x01E8 sets timeout
// - write reply echoes point and value
// - failure reply fc plus 0x80, code
// - eight live input points 00033..00040
// - latched-high flags at 00065..00072
// - latched-low flags at 00097..00104
// - write to 00264 clears latches
// - input counters at 30001..30008
// - writes 00513..00520 clear matching counter
// - coils 00001..00008 drive digital outputs
`timescale 1ns/1ns
`default_nettype none
`include "mhwio_defs.vh"
module mhwio_core #(
	parameter [23:0] TENTH_CYCLES = `MHWIO_TENTH_CYCLES
) (
	// clock and reset
	input wire CLK,
	input wire RSTN,
	// station strap, static
	input wire [7:0] STATION_ADDR,
	// request bytes from the serial layer
	input wire RX_VALID,
	input wire [7:0] RX_DATA,
	input wire RX_END,
	// reply bytes to the serial layer
	output reg TX_VALID,
	output reg [7:0] TX_DATA,
	output reg TX_LAST,
	input wire TX_READY,
	// field pins
	input wire [7:0] DIGITAL_INPUT,
	output reg [7:0] DIGITAL_OUTPUT,
	// watchdog state
	output reg HOST_WATCHDOG_ENABLED,
	output reg HOST_WATCHDOG_EXPIRED
);
	localparam ST_IDLE = 1'b0;
	localparam ST_SEND = 1'b1;
	localparam K_EXC = 2'b00;
	localparam K_BITS = 2'b01;
	localparam K_REGS = 2'b10;
	localparam K_ECHO = 2'b11;

	// true when the point sits in the given group of eight
	function in_grp;
		input [15:0] pt;
		input [12:0] grp;
		begin
			in_grp = (pt[15:3] == grp);
		end
	endfunction

	// a quantity 1..8 that stays within its group of eight
	function qty_ok;
		input [15:0] pt;
		input [15:0] qty;
		begin
			qty_ok = (qty != 16'h0000) && (qty <= 16'h0008) &&
				({1'b0, pt[2:0]} + qty[3:0] <= 4'h8);
		end
	endfunction

	reg state_ff;
	reg [2:0] rx_cnt_ff;
	reg [7:0] fr_addr_ff, fr_fc_ff;
	reg [15:0] fr_pt_ff, fr_val_ff;
	reg [1:0] kind_ff;
	reg [7:0] exc_ff, bits_ff;
	reg [4:0] len_ff, idx_ff;
	reg [7:0] timeout_ff;
	reg [23:0] pre_ff;
	reg [7:0] elapsed_ff;
	wire [7:0] di_now, lat_hi, lat_lo;
	wire [127:0] cnt_all;

	// ------------------------------------------------------------
	// request capture
	// ------------------------------------------------------------
	wire sta_ok = (STATION_ADDR >= `MHWIO_STA_MIN) &&
		(STATION_ADDR <= `MHWIO_STA_MAX);
	wire frame_ok = RX_END && (state_ff == ST_IDLE) &&
		(rx_cnt_ff == 3'h6) && sta_ok &&
		(fr_addr_ff == STATION_ADDR);

	// bytes after the sixth are counted but dropped, so long frames
	// fall out as malformed; nothing is captured while replying
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rx_cnt_ff <= 3'h0;
			fr_addr_ff <= 8'h00;
			fr_fc_ff <= 8'h00;
			fr_pt_ff <= 16'h0000;
			fr_val_ff <= 16'h0000;
		end else if (RX_END) begin
			rx_cnt_ff <= 3'h0;
		end else if (RX_VALID && state_ff == ST_IDLE) begin
			if (rx_cnt_ff != 3'h7)
				rx_cnt_ff <= rx_cnt_ff + 3'h1;
			case (rx_cnt_ff)
			3'h0: fr_addr_ff <= RX_DATA;
			3'h1: fr_fc_ff <= RX_DATA;
			3'h2: fr_pt_ff[15:8] <= RX_DATA;
			3'h3: fr_pt_ff[7:0] <= RX_DATA;
			3'h4: fr_val_ff[15:8] <= RX_DATA;
			3'h5: fr_val_ff[7:0] <= RX_DATA;
			default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	reg d_act, d_alive, d_do_we, d_en_we, d_exp_clr, d_lat_clr, d_to_we;
	reg [1:0] d_kind;
	reg [7:0] d_exc, d_bits, d_cnt_clr, grp;
	reg [4:0] d_len;
	reg gok;
	wire coil_legal = (fr_val_ff == `MHWIO_COIL_ON) ||
		(fr_val_ff == `MHWIO_COIL_OFF);
	wire coil_on = (fr_val_ff == `MHWIO_COIL_ON);
	wire [7:0] qmask = 8'hFF >> (4'h8 - fr_val_ff[3:0]);

	always @* begin
		d_act = 1'b0;
		d_alive = 1'b0;
		d_do_we = 1'b0;
		d_en_we = 1'b0;
		d_exp_clr = 1'b0;
		d_lat_clr = 1'b0;
		d_to_we = 1'b0;
		d_cnt_clr = 8'h00;
		d_kind = K_EXC;
		d_exc = `MHWIO_EX_ADDR;
		d_bits = 8'h00;
		d_len = 5'h03;
		gok = 1'b1;
		case (fr_pt_ff[15:3])
		`MHWIO_GRP_COIL: grp = DIGITAL_OUTPUT;
		`MHWIO_GRP_DI: grp = di_now;
		`MHWIO_GRP_LAT_HI: grp = lat_hi;
		`MHWIO_GRP_LAT_LO: grp = lat_lo;
		`MHWIO_GRP_WD: grp = {7'h00, HOST_WATCHDOG_EXPIRED}
			<< `MHWIO_WD_EXP_POS;
		default: begin
			grp = 8'h00;
			gok = 1'b0;
		end
		endcase
		if (frame_ok) begin
			d_act = 1'b1;
			case (fr_fc_ff)
			`MHWIO_FC_RD_COILS, `MHWIO_FC_RD_DI: begin
				if (!gok)
					d_exc = `MHWIO_EX_ADDR;
				else if (!qty_ok(fr_pt_ff, fr_val_ff))
					d_exc = `MHWIO_EX_VAL;
				else begin
					d_kind = K_BITS;
					d_len = 5'h04;
					d_bits = (grp >> fr_pt_ff[2:0]) & qmask;
				end
			end
			`MHWIO_FC_RD_HOLD, `MHWIO_FC_RD_INP: begin
				if (fr_pt_ff == `MHWIO_PT_ALIVE &&
					fr_val_ff == `MHWIO_ALIVE_WORD) begin
					d_act = 1'b0;
					d_alive = 1'b1;
				end else if ((fr_pt_ff == `MHWIO_PT_TIMEOUT &&
					fr_val_ff == `MHWIO_QTY_ONE) ||
					(in_grp(fr_pt_ff, `MHWIO_GRP_COIL) &&
					qty_ok(fr_pt_ff, fr_val_ff))) begin
					d_kind = K_REGS;
					d_len = 5'h03 + {fr_val_ff[3:0], 1'b0};
				end
			end
			`MHWIO_FC_WR_COIL: begin
				if (!coil_legal)
					d_exc = `MHWIO_EX_VAL;
				else if (in_grp(fr_pt_ff, `MHWIO_GRP_COIL))
					d_do_we = 1'b1;
				else if (fr_pt_ff == `MHWIO_PT_WD_EN)
					d_en_we = 1'b1;
				else if (fr_pt_ff == `MHWIO_PT_WD_EXP)
					d_exp_clr = coil_on;
				else if (fr_pt_ff == `MHWIO_PT_LAT_CLR)
					d_lat_clr = coil_on;
				else if (in_grp(fr_pt_ff, `MHWIO_GRP_CNT_CLR))
					d_cnt_clr = {7'h00, coil_on}
						<< fr_pt_ff[2:0];
				if (coil_legal && (d_do_we || d_en_we ||
					fr_pt_ff == `MHWIO_PT_WD_EXP ||
					fr_pt_ff == `MHWIO_PT_LAT_CLR ||
					in_grp(fr_pt_ff, `MHWIO_GRP_CNT_CLR))) begin
					d_kind = K_ECHO;
					d_len = 5'h06;
				end
			end
			`MHWIO_FC_WR_REG: begin
				if (fr_pt_ff != `MHWIO_PT_TIMEOUT)
					d_exc = `MHWIO_EX_ADDR;
				else if (fr_val_ff[15:8] != 8'h00)
					d_exc = `MHWIO_EX_VAL;
				else begin
					d_to_we = 1'b1;
					d_kind = K_ECHO;
					d_len = 5'h06;
				end
			end
			default: d_exc = `MHWIO_EX_FUNC;
			endcase
		end
	end

	// ------------------------------------------------------------
	// reply sequencer
	// ------------------------------------------------------------
	wire [4:0] j = idx_ff - 5'h03;
	wire [2:0] ci = fr_pt_ff[2:0] + j[3:1];
	wire [15:0] word = (fr_pt_ff == `MHWIO_PT_TIMEOUT) ?
		{8'h00, timeout_ff} : cnt_all[{ci, 4'h0} +: 16];
	reg [7:0] nxt_byte;

	// bytes are built on the fly, so counters are read live
	always @* begin
		case (idx_ff)
		5'h00: nxt_byte = fr_addr_ff;
		5'h01: nxt_byte = (kind_ff == K_EXC) ?
			(fr_fc_ff | `MHWIO_FC_EXC) : fr_fc_ff;
		5'h02: nxt_byte = (kind_ff == K_EXC) ? exc_ff :
			(kind_ff == K_BITS) ? 8'h01 :
			(kind_ff == K_REGS) ? {3'h0, len_ff - 5'h03} :
			fr_pt_ff[15:8];
		5'h03: nxt_byte = (kind_ff == K_BITS) ? bits_ff :
			(kind_ff == K_ECHO) ? fr_pt_ff[7:0] : word[15:8];
		5'h04: nxt_byte = (kind_ff == K_ECHO) ? fr_val_ff[15:8] :
			word[7:0];
		5'h05: nxt_byte = (kind_ff == K_ECHO) ? fr_val_ff[7:0] :
			word[15:8];
		default: nxt_byte = j[0] ? word[7:0] : word[15:8];
		endcase
	end

	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_ff <= ST_IDLE;
			kind_ff <= K_EXC;
			exc_ff <= 8'h00;
			bits_ff <= 8'h00;
			len_ff <= 5'h00;
			idx_ff <= 5'h00;
			TX_VALID <= 1'b0;
			TX_DATA <= 8'h00;
			TX_LAST <= 1'b0;
		end else begin
			case (state_ff)
			ST_IDLE: begin
				idx_ff <= 5'h00;
				if (d_act) begin
					state_ff <= ST_SEND;
					kind_ff <= d_kind;
					exc_ff <= d_exc;
					bits_ff <= d_bits;
					len_ff <= d_len;
				end
			end
			ST_SEND: begin
				if (!TX_VALID || TX_READY) begin
					if (idx_ff < len_ff) begin
						TX_VALID <= 1'b1;
						TX_DATA <= nxt_byte;
						TX_LAST <= (idx_ff == len_ff - 5'h01);
						idx_ff <= idx_ff + 5'h01;
					end else begin
						TX_VALID <= 1'b0;
						TX_LAST <= 1'b0;
						state_ff <= ST_IDLE;
					end
				end
			end
			default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// outputs, timeout and watchdog
	// ------------------------------------------------------------
	wire tick = (pre_ff == TENTH_CYCLES - 24'h000001);
	wire restart = d_alive || d_en_we || !HOST_WATCHDOG_ENABLED;
	wire expire = HOST_WATCHDOG_ENABLED && timeout_ff != 8'h00 &&
		elapsed_ff >= timeout_ff;

	// a zero timeout never expires; expiry wins over a clear
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			DIGITAL_OUTPUT <= `MHWIO_DO_RST;
			HOST_WATCHDOG_ENABLED <= 1'b0;
			HOST_WATCHDOG_EXPIRED <= 1'b0;
			timeout_ff <= `MHWIO_TIMEOUT_RST;
			pre_ff <= 24'h000000;
			elapsed_ff <= 8'h00;
		end else begin
			if (d_do_we)
				DIGITAL_OUTPUT[fr_pt_ff[2:0]] <= coil_on;
			if (d_en_we)
				HOST_WATCHDOG_ENABLED <= coil_on;
			if (d_to_we)
				timeout_ff <= fr_val_ff[7:0];
			HOST_WATCHDOG_EXPIRED <= expire ||
				(HOST_WATCHDOG_EXPIRED && !d_exp_clr);
			if (restart) begin
				pre_ff <= 24'h000000;
				elapsed_ff <= 8'h00;
			end else begin
				pre_ff <= tick ? 24'h000000 : pre_ff + 24'h000001;
				if (tick && elapsed_ff != 8'hFF)
					elapsed_ff <= elapsed_ff + 8'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// per-input sync, latches and counters
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_in
			reg s1_ff, s2_ff, s3_ff, lvl_ff, lh_ff, ll_ff;
			reg [15:0] cnt_ff;
			wire agree = (s2_ff == s3_ff);
			wire rise = agree && s3_ff && !lvl_ff;
			wire fall = agree && !s3_ff && lvl_ff;
			assign di_now[i] = lvl_ff;
			assign lat_hi[i] = lh_ff;
			assign lat_lo[i] = ll_ff;
			assign cnt_all[16*i +: 16] = cnt_ff;
			// edge counts wrap; an edge beats a same-cycle clear
			always @(posedge CLK or negedge RSTN) begin
				if (!RSTN) begin
					s1_ff <= 1'b0;
					s2_ff <= 1'b0;
					s3_ff <= 1'b0;
					lvl_ff <= 1'b0;
					lh_ff <= 1'b0;
					ll_ff <= 1'b0;
					cnt_ff <= 16'h0000;
				end else begin
					s1_ff <= DIGITAL_INPUT[i];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					if (agree)
						lvl_ff <= s3_ff;
					lh_ff <= rise || (lh_ff && !d_lat_clr);
					ll_ff <= fall || (ll_ff && !d_lat_clr);
					if (rise)
						cnt_ff <= d_cnt_clr[i] ? 16'h0001 :
							cnt_ff + 16'h0001;
					else if (d_cnt_clr[i])
						cnt_ff <= 16'h0000;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ---- mhwio_defs.vh ----
/*
 * Constants of the host watchdog and point map block: function codes,
 * point addresses, coil values, exception codes, reset values, timing.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef MHWIO_DEFS_VH
`define MHWIO_DEFS_VH
// function codes
`define MHWIO_FC_RD_COILS 8'h01
`define MHWIO_FC_RD_DI 8'h02
`define MHWIO_FC_RD_HOLD 8'h03
`define MHWIO_FC_RD_INP 8'h04
`define MHWIO_FC_WR_COIL 8'h05
`define MHWIO_FC_WR_REG 8'h06
`define MHWIO_FC_EXC 8'h80
// point addresses (zero based on the wire)
`define MHWIO_PT_WD_EN 16'h0104
`define MHWIO_PT_WD_EXP 16'h010D
`define MHWIO_PT_LAT_CLR 16'h0107
`define MHWIO_PT_TIMEOUT 16'h01E8
`define MHWIO_PT_ALIVE 16'h3038
`define MHWIO_GRP_COIL 13'h0000
`define MHWIO_GRP_DI 13'h0004
`define MHWIO_GRP_LAT_HI 13'h0008
`define MHWIO_GRP_LAT_LO 13'h000C
`define MHWIO_GRP_WD 13'h0021
`define MHWIO_GRP_CNT_CLR 13'h0040
`define MHWIO_WD_EXP_POS 5
// coil values and quantities
`define MHWIO_COIL_ON 16'hFF00
`define MHWIO_COIL_OFF 16'h0000
`define MHWIO_QTY_ONE 16'h0001
`define MHWIO_ALIVE_WORD 16'h0000
// exception codes
`define MHWIO_EX_FUNC 8'h01
`define MHWIO_EX_ADDR 8'h02
`define MHWIO_EX_VAL 8'h03
// station address range
`define MHWIO_STA_MIN 8'h01
`define MHWIO_STA_MAX 8'hF7
// reset values
`define MHWIO_TIMEOUT_RST 8'h00
`define MHWIO_DO_RST 8'h00
// timing: one timeout count is 0.1 s, ten million 10 ns cycles
`define MHWIO_TENTH_CYCLES 24'h989680
`endif

// ---- mhwio_chk_assertions.sv ----
/* checker on the ports of the watchdog core
   assumes binding to mhwio_core from the testbench */
`timescale 1ns/1ns
`default_nettype none
module mhwio_chk (
	// clock and reset
	input wire logic CLK,
	input wire logic RSTN,
	// request side
	input wire logic [7:0] STATION_ADDR,
	input wire logic RX_END,
	// reply side
	input wire logic TX_VALID,
	input wire logic [7:0] TX_DATA,
	input wire logic TX_LAST,
	input wire logic TX_READY,
	// outputs
	input wire logic [7:0] DIGITAL_OUTPUT,
	input wire logic HOST_WATCHDOG_ENABLED,
	input wire logic HOST_WATCHDOG_EXPIRED
);
	// ----
	// reply and state checks
	// ----
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// final byte taken by the serial layer
	sequence s_last_taken;
		TX_VALID && TX_READY && TX_LAST;
	endsequence
	a_tx_hold: assert property (
		TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
		else $error("stalled byte moved");
	a_reply_end: assert property (s_last_taken |=> !TX_VALID)
		else $error("reply ran on");
	a_reply_addr: assert property (
		$rose(TX_VALID) |-> TX_DATA == STATION_ADDR)
		else $error("reply not from own station");
	a_bad_station: assert property (
		STATION_ADDR == 8'h00 |-> !TX_VALID)
		else $error("reply at station zero");
	// state moves only one edge after a frame end; expiry rises only one edge after enabled
	a_en_cause: assert property (
		$changed(HOST_WATCHDOG_ENABLED) |-> $past(RX_END))
		else $error("enable moved alone");
	a_do_cause: assert property (
		$changed(DIGITAL_OUTPUT) |-> $past(RX_END))
		else $error("outputs moved alone");
	a_clr_cause: assert property (
		$fell(HOST_WATCHDOG_EXPIRED) |-> $past(RX_END))
		else $error("expired fell alone");
	a_exp_cause: assert property (
		$rose(HOST_WATCHDOG_EXPIRED) |-> $past(HOST_WATCHDOG_ENABLED))
		else $error("expired while disabled");
endmodule
`default_nettype wire

// ---- mhwio_host_model.sv ----
/* host model: sends request frames, gathers reply bytes
   assumes the core samples both sides on rising CLK */
`timescale 1ns/1ns
`default_nettype none
module mhwio_host (
	// clock
	input wire logic clk,
	// request bytes
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_end,
	// reply bytes
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready
);
	// ----
	// frame exchange
	// ----
	logic [7:0] rsp[$];
	logic slow = 1'b0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_end = 1'b0;
	end
	// a busy serial layer stalls at random once slow is set
	always @(posedge clk)
		tx_ready <= !slow || $urandom_range(1);
	// no reply is seen as silence over a fixed wait
	task automatic xfer(input logic [47:0] f);
		int last_n;
		last_n = 0;
		rsp = {};
		for (int i = 5; i >= 0; i--) begin
			@(posedge clk);
			rx_valid <= 1'b1;
			rx_data <= f[8*i +: 8];
		end
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data <= ~f[7:0]; // stale byte must not look valid
		rx_end <= 1'b1;
		@(posedge clk);
		rx_end <= 1'b0;
		repeat (60) begin
			@(posedge clk);
			if (tx_valid && tx_ready) begin
				rsp.push_back(tx_data);
				if (tx_last)
					last_n = rsp.size();
			end
		end
		// a missing or misplaced last mark spoils the byte count
		if (last_n != rsp.size())
			rsp.push_back(8'h00);
	endtask
endmodule
`default_nettype wire

// ---- mhwio_tb.sv ----
/* self-checking bench for the watchdog core
   assumes core, host model and checker compiled before it */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic CLK = 1'b0;
	logic RSTN = 1'b0;
	logic [7:0] sta = 8'h01;
	logic [7:0] din = 8'h00;
	logic rx_valid, rx_end, tx_valid, tx_last, tx_ready, wd_en, wd_exp;
	logic [7:0] rx_data, tx_data, dout, v, d;
	int err_count = 0;
	int tests_run = 0;
	always #5 CLK = ~CLK;
	// a tenth shortened to ten cycles keeps the run brief
	mhwio_core #(.TENTH_CYCLES(24'h00000A)) mhwio_core_i (.CLK(CLK),
		.RSTN(RSTN), .STATION_ADDR(sta), .RX_VALID(rx_valid),
		.RX_DATA(rx_data), .RX_END(rx_end), .TX_VALID(tx_valid),
		.TX_DATA(tx_data), .TX_LAST(tx_last), .TX_READY(tx_ready),
		.DIGITAL_INPUT(din), .DIGITAL_OUTPUT(dout),
		.HOST_WATCHDOG_ENABLED(wd_en), .HOST_WATCHDOG_EXPIRED(wd_exp));
	mhwio_host host_i (.clk(CLK), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_end(rx_end), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_last(tx_last), .tx_ready(tx_ready));
	// ----
	// helpers
	// ----
	task end_of_test;
		if (err_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk_rsp(input logic [63:0] e, input int n);
		logic ok;
		ok = host_i.rsp.size() == n;
		for (int i = 0; i < n && ok; i++)
			ok = host_i.rsp[i] === e[8*(n-1-i) +: 8];
		tests_run++;
		if (!ok) begin
			err_count++;
			$display("[FAIL] %0t reply, want %h", $time, e);
		end
	endtask
	task automatic chk_lvl(input logic [7:0] g, e);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t level %h, want %h", $time, g, e);
		end
	endtask
	task automatic go(input logic [7:0] fc, input logic [15:0] pt, val);
		host_i.xfer({8'h01, fc, pt, val});
	endtask
	// a write is answered by its own echo
	task automatic wr(input logic [7:0] fc, input logic [15:0] pt, val);
		go(fc, pt, val);
		chk_rsp({8'h01, fc, pt, val}, 6);
	endtask
	function automatic logic [63:0] bits(input logic [7:0] fc, b);
		return {32'h0, 8'h01, fc, 8'h01, b};
	endfunction
	initial begin
		#100000;
		err_count++;
		end_of_test();
	end
	// ----
	// scenarios
	// ----
	initial begin
		void'($urandom(32'hB11C));
		repeat (6) @(posedge CLK);
		RSTN <= 1'b1;
		v = $urandom;
		wr(8'h06, 16'h01E8, {8'h00, v});
		go(8'h06, 16'h01E8, 16'h0100);
		chk_rsp({8'h01, 8'h86, 8'h03}, 3);
		go(8'h05, 16'h0104, 16'h1234);
		chk_rsp({8'h01, 8'h85, 8'h03}, 3);
		go(8'h03, 16'h0100, 16'h0001);
		chk_rsp({8'h01, 8'h83, 8'h02}, 3);
		go(8'h01, 16'h010D, 16'h0004);
		chk_rsp({8'h01, 8'h81, 8'h03}, 3);
		go(8'h07, 16'h0000, 16'h0001);
		chk_rsp({8'h01, 8'h87, 8'h01}, 3);
		// a frame at station zero, at station 0xF8 or to another station is dropped silently
		sta <= 8'h00;
		go(8'h06, 16'h01E8, 16'h0014);
		chk_rsp(64'h0, 0);
		sta <= 8'hF8;
		host_i.xfer({8'hF8, 8'h06, 16'h01E8, 16'h0014});
		chk_rsp(64'h0, 0);
		sta <= 8'h01;
		host_i.xfer({8'h02, 8'h06, 16'h01E8, 16'h0014});
		chk_rsp(64'h0, 0);
		go(8'h03, 16'h01E8, 16'h0001);
		chk_rsp({8'h01, 8'h03, 8'h02, 8'h00, v}, 5);
		// kept alive, then silent past twenty tenths
		wr(8'h06, 16'h01E8, 16'h0014);
		wr(8'h05, 16'h0104, 16'hFF00);
		for (int i = 0; i < 4; i++) begin
			go(i[0] ? 8'h04 : 8'h03, 16'h3038, 16'h0000);
			chk_rsp(64'h0, 0);
		end
		repeat (120) @(posedge CLK);
		chk_lvl({6'h00, wd_en, wd_exp}, 8'h02);
		repeat (40) @(posedge CLK);
		chk_lvl({7'h00, wd_exp}, 8'h01);
		go(8'h01, 16'h010D, 16'h0001);
		chk_rsp(bits(8'h01, 8'h01), 4);
		wr(8'h05, 16'h0104, 16'h0000);
		chk_lvl({6'h00, wd_en, wd_exp}, 8'h01);
		wr(8'h05, 16'h010D, 16'hFF00);
		go(8'h01, 16'h010D, 16'h0001);
		chk_rsp(bits(8'h01, 8'h00), 4);
		// coils under a stalling serial layer
		host_i.slow <= 1'b1;
		d = $urandom;
		for (int i = 0; i < 8; i++)
			wr(8'h05, i[15:0], d[i] ? 16'hFF00 : 16'h0000);
		chk_lvl(dout, d);
		go(8'h01, 16'h0000, 16'h0008);
		chk_rsp(bits(8'h01, d), 4);
		// inputs: live, latched both ways, counted
		wr(8'h05, 16'h0200, 16'hFF00);
		wr(8'h05, 16'h0107, 16'hFF00);
		d = $urandom | 8'h01;
		din <= d;
		go(8'h02, 16'h0020, 16'h0008);
		chk_rsp(bits(8'h02, d), 4);
		din <= 8'h00;
		go(8'h02, 16'h0040, 16'h0008);
		chk_rsp(bits(8'h02, d), 4);
		go(8'h02, 16'h0060, 16'h0008);
		chk_rsp(bits(8'h02, d), 4);
		go(8'h04, 16'h0000, 16'h0001);
		chk_rsp(40'h0104020001, 5);
		wr(8'h05, 16'h0200, 16'hFF00);
		wr(8'h05, 16'h0107, 16'hFF00);
		go(8'h04, 16'h0000, 16'h0001);
		chk_rsp(40'h0104020000, 5);
		go(8'h02, 16'h0040, 16'h0008);
		chk_rsp(bits(8'h02, 8'h00), 4);
		end_of_test();
	end
endmodule
bind mhwio_core mhwio_chk mhwio_chk_i (.CLK(CLK), .RSTN(RSTN),
	.STATION_ADDR(STATION_ADDR), .RX_END(RX_END), .TX_VALID(TX_VALID),
	.TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .TX_READY(TX_READY),
	.DIGITAL_OUTPUT(DIGITAL_OUTPUT),
	.HOST_WATCHDOG_ENABLED(HOST_WATCHDOG_ENABLED),
	.HOST_WATCHDOG_EXPIRED(HOST_WATCHDOG_EXPIRED));
`default_nettype wire
